// ### hw/alu_ops_pkg.sv
package alu_ops_pkg;

  // ************************************************************
  // Opcode encodings (upper byte patterns, upper six-bit patterns for the file adds)
  // ************************************************************
  localparam logic [7:0] OP_ADD_IMM = 8'h0F;
  localparam logic [7:0] OP_AND_IMM = 8'h0B;
  localparam logic [5:0] OP_ADD_FILE = 6'h09;
  localparam logic [5:0] OP_ADD_CARRY = 6'h08;

  // ************************************************************
  // Instruction word fields
  // ************************************************************
  localparam int HI_MSB = 15;
  localparam int HI_LSB = 8;
  localparam int OP6_LSB = 10;
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  localparam int LIT_MSB = 7;

  // ************************************************************
  // Status flag positions and addressing constants
  // ************************************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;
  localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [4:0] STATUS_RESET = 5'h00;

  typedef enum logic [1:0] {
    PH_DECODE = 2'b00,
    PH_READ = 2'b01,
    PH_PROCESS = 2'b10,
    PH_WRITE = 2'b11
  } phase_type;

  typedef enum logic [2:0] {
    OPK_NONE = 3'b000,
    OPK_ADD_IMM = 3'b001,
    OPK_ADD_FILE = 3'b010,
    OPK_ADD_CARRY = 3'b011,
    OPK_AND_IMM = 3'b100
  } opkind_type;

endpackage : alu_ops_pkg

// ### hw/alu_ops.sv
`timescale 1ns/1ns
module alu_ops
  import alu_ops_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  // Instruction from decode
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic ext_set_enable,
  input wire logic [3:0] bank_select_register,
  input wire logic [11:0] index_base,
  // Data memory
  output logic [11:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  // State seen by the core
  output logic [7:0] acc_out,
  output logic [4:0] status_out,
  output logic [1:0] phase_out,
  output logic busy,
  output logic done
);
  import alu_ops_pkg::*;

  // ************************************************************
  // Reset release
  // ************************************************************
  logic rst_s1_reg;
  logic rst_s2_reg;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire logic rst_n_int = rst_s2_reg;

  // ************************************************************
  // Decode
  // ************************************************************
  opkind_type kind_next;
  always_comb begin
    kind_next = OPK_NONE;
    if (instr_word[HI_MSB:HI_LSB] == OP_ADD_IMM) begin
      kind_next = OPK_ADD_IMM;
    end else if (instr_word[HI_MSB:HI_LSB] == OP_AND_IMM) begin
      kind_next = OPK_AND_IMM;
    end else if (instr_word[HI_MSB:OP6_LSB] == OP_ADD_FILE) begin
      kind_next = OPK_ADD_FILE;
    end else if (instr_word[HI_MSB:OP6_LSB] == OP_ADD_CARRY) begin
      kind_next = OPK_ADD_CARRY;
    end
  end

  phase_type phase_reg;
  opkind_type kind_reg;
  logic dest_reg;
  logic [7:0] lit_reg;
  logic [11:0] addr_reg;
  logic [7:0] operand_reg;
  logic [7:0] result_reg;
  logic [4:0] flags_res_reg;
  logic [7:0] acc_reg;
  logic [4:0] status_reg;
  logic done_reg;

  // Effective address of the file operand
  logic [11:0] addr_next;
  always_comb begin
    addr_next = {bank_select_register, instr_word[LIT_MSB:0]};
    if (!instr_word[BANK_BIT]) begin
      if (ext_set_enable && instr_word[LIT_MSB:0] <= INDEXED_LIMIT) begin
        addr_next = index_base + {4'h0, instr_word[LIT_MSB:0]};
      end else if (instr_word[LIT_MSB:0] >= ACCESS_SPLIT) begin
        addr_next = {ACCESS_HIGH_BANK, instr_word[LIT_MSB:0]};
      end else begin
        addr_next = {ACCESS_LOW_BANK, instr_word[LIT_MSB:0]};
      end
    end
  end

  // ************************************************************
  // Phase sequencer: decode, read, process, write
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      phase_reg <= PH_DECODE;
    end else if (clk_en) begin
      case (phase_reg)
        PH_DECODE: begin
          if (instr_valid && kind_next != OPK_NONE) begin
            phase_reg <= PH_READ;
          end
        end
        PH_READ: phase_reg <= PH_PROCESS;
        PH_PROCESS: phase_reg <= PH_WRITE;
        PH_WRITE: phase_reg <= PH_DECODE;
        default: phase_reg <= PH_DECODE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      kind_reg <= OPK_NONE;
      dest_reg <= 1'b0;
      lit_reg <= 8'h00;
      addr_reg <= 12'h000;
    end else if (clk_en && phase_reg == PH_DECODE && instr_valid && kind_next != OPK_NONE) begin
      kind_reg <= kind_next;
      dest_reg <= instr_word[DEST_BIT];
      lit_reg <= instr_word[LIT_MSB:0];
      addr_reg <= addr_next;
    end
  end

  // Operand read: immediate or data memory byte
  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      operand_reg <= 8'h00;
    end else if (clk_en && phase_reg == PH_READ) begin
      if (kind_reg == OPK_ADD_FILE || kind_reg == OPK_ADD_CARRY) begin
        operand_reg <= mem_rdata;
      end else begin
        operand_reg <= lit_reg;
      end
    end
  end

  // ************************************************************
  // Arithmetic
  // ************************************************************
  logic cin;
  logic [8:0] sum9;
  logic [4:0] low5;
  logic [7:0] res;
  logic [4:0] fl;
  always_comb begin
    cin = (kind_reg == OPK_ADD_CARRY) ? status_reg[FLAG_C] : 1'b0;
    sum9 = {1'b0, acc_reg} + {1'b0, operand_reg} + {8'h00, cin};
    low5 = {1'b0, acc_reg[3:0]} + {1'b0, operand_reg[3:0]} + {4'h0, cin};
    fl = status_reg;
    res = sum9[7:0];
    if (kind_reg == OPK_AND_IMM) begin
      res = acc_reg & operand_reg;
      fl[FLAG_Z] = (res == 8'h00);
      fl[FLAG_N] = res[7];
    end else begin
      fl[FLAG_C] = sum9[8];
      fl[FLAG_DC] = low5[4];
      fl[FLAG_Z] = (res == 8'h00);
      fl[FLAG_N] = res[7];
      fl[FLAG_OV] = (acc_reg[7] == operand_reg[7]) && (res[7] != acc_reg[7]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      result_reg <= 8'h00;
      flags_res_reg <= STATUS_RESET;
    end else if (clk_en && phase_reg == PH_PROCESS) begin
      result_reg <= res;
      flags_res_reg <= fl;
    end
  end

  // ************************************************************
  // Write to destination
  // ************************************************************
  wire logic to_file = (kind_reg == OPK_ADD_FILE || kind_reg == OPK_ADD_CARRY) && dest_reg;

  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      acc_reg <= ACC_RESET;
      status_reg <= STATUS_RESET;
      done_reg <= 1'b0;
    end else if (clk_en) begin
      done_reg <= (phase_reg == PH_WRITE);
      if (phase_reg == PH_WRITE) begin
        status_reg <= flags_res_reg;
        if (!to_file) begin
          acc_reg <= result_reg;
        end
      end
    end
  end

  assign mem_addr = addr_reg;
  assign mem_wdata = result_reg;
  assign mem_we = clk_en && phase_reg == PH_WRITE && to_file;
  assign acc_out = acc_reg;
  assign status_out = status_reg;
  assign phase_out = phase_reg;
  assign busy = (phase_reg != PH_DECODE);
  assign done = done_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence write_phase_s;
    phase_reg == PH_WRITE && clk_en;
  endsequence

  phase_order_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
    (phase_reg == PH_READ && clk_en) |=> phase_reg == PH_PROCESS)
    else $error("read phase not followed by process");
  acc_dest_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
    (write_phase_s and to_file) |=> acc_reg == $past(acc_reg))
    else $error("accumulator changed on file write");
  file_we_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
    mem_we |-> dest_reg && kind_reg != OPK_ADD_IMM && kind_reg != OPK_AND_IMM)
    else $error("file written by wrong instruction");
  carry_add_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
    (phase_reg == PH_PROCESS && clk_en && kind_reg == OPK_ADD_CARRY)
      |=> result_reg == 8'(acc_reg + operand_reg + {7'h00, status_reg[FLAG_C]}))
    else $error("carry add result wrong");
  carry_decode_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
    (instr_word[HI_MSB:OP6_LSB] == OP_ADD_CARRY) |-> kind_next == OPK_ADD_CARRY)
    else $error("carry add not decoded");
  zero_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
    write_phase_s |=> status_reg[FLAG_Z] == ($past(result_reg) == 8'h00))
    else $error("zero flag wrong");
  bank_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
    instr_word[BANK_BIT] |-> addr_next == {bank_select_register, instr_word[LIT_MSB:0]})
    else $error("banked address wrong");
  indexed_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
    (!instr_word[BANK_BIT] && ext_set_enable && instr_word[LIT_MSB:0] <= INDEXED_LIMIT)
      |-> addr_next == index_base + {4'h0, instr_word[LIT_MSB:0]})
    else $error("indexed address wrong");
  and_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
    (write_phase_s and kind_reg == OPK_AND_IMM)
      |=> status_reg[FLAG_C] == $past(status_reg[FLAG_C])
       && status_reg[FLAG_OV] == $past(status_reg[FLAG_OV]))
    else $error("and changed carry or overflow");
  and_result_a: assert property (@(posedge clk_sys) disable iff (!rst_n_int)
    (phase_reg == PH_PROCESS && clk_en && kind_reg == OPK_AND_IMM)
      ##1 (phase_reg == PH_WRITE && clk_en) |=> acc_reg == $past(result_reg))
    else $error("and result not in accumulator");

endmodule : alu_ops

// ### tb/data_mem_model.sv
`timescale 1ns/1ns
module data_mem_model (
  // Clock
  input wire logic clk_sys,
  // Data memory port
  input wire logic [11:0] mem_addr,
  output logic [7:0] mem_rdata,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we
);
  // ************************************************************
  // Banked byte store
  // ************************************************************
  logic [7:0] cells [0:4095];
  // Unwritten cells read as unknown, so a wrong address cannot pass by luck
  assign mem_rdata = cells[mem_addr];
  always @(posedge clk_sys) begin
    if (mem_we === 1'b1) begin
      cells[mem_addr] <= mem_wdata;
    end
  end
endmodule : data_mem_model

// ### tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import alu_ops_pkg::*;
  // ************************************************************
  // Stimulus and observed signals
  // ************************************************************
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic ext_set_enable = 1'b0;
  logic [3:0] bank_select_register = 4'h0;
  logic [11:0] index_base = 12'h200;
  logic [11:0] mem_addr;
  logic [7:0] mem_rdata;
  logic [7:0] mem_wdata;
  logic mem_we;
  logic [7:0] acc_out;
  logic [4:0] status_out;
  logic [1:0] phase_out;
  logic busy;
  logic done;
  logic [7:0] acc_m = 8'h00;
  logic [4:0] st_m = 5'h00;
  int err_count = 0;
  int check_count = 0;
  always #20 clk_sys = ~clk_sys;
  alu_ops dut (.clk_sys, .rst_b, .clk_en, .instr_valid, .instr_word, .ext_set_enable,
    .bank_select_register, .index_base, .mem_addr, .mem_rdata, .mem_wdata, .mem_we,
    .acc_out, .status_out, .phase_out, .busy, .done);
  data_mem_model mem (.clk_sys, .mem_addr, .mem_rdata, .mem_wdata, .mem_we);
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %0s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask : step
  // Runs one instruction through the four phases and predicts its effect
  task automatic exec(input logic [15:0] word, input logic [11:0] addr, input bit stall);
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] opnd;
    logic [7:0] res;
    logic cin;
    logic file_op;
    logic to_file;
    int n;
    n = 0;
    while (busy !== 1'b0) begin
      step();
      n++;
      if (n > 8) begin
        err_count++;
        report_and_stop();
      end
    end
    file_op = (word[15:10] == OP_ADD_FILE) || (word[15:10] == OP_ADD_CARRY);
    to_file = file_op && word[DEST_BIT];
    opnd = file_op ? mem.cells[addr] : word[7:0];
    cin = (word[15:10] == OP_ADD_CARRY) ? st_m[FLAG_C] : 1'b0;
    instr_valid = 1'b1;
    instr_word = word;
    step();
    instr_valid = 1'b0;
    check("phase read", phase_out, PH_READ);
    check("busy", busy, 1'b1);
    check("done low", done, 1'b0);
    if (file_op) begin
      check("operand address", mem_addr, addr);
    end
    if (stall) begin
      // A frozen clock enable must not let the phase advance
      clk_en = 1'b0;
      step();
      step();
      check("phase held", phase_out, PH_READ);
      clk_en = 1'b1;
    end
    step();
    check("phase process", phase_out, PH_PROCESS);
    step();
    check("phase write", phase_out, PH_WRITE);
    check("write enable", mem_we, to_file);
    if (word[15:8] == OP_AND_IMM) begin
      res = acc_m & opnd;
    end else begin
      sum = acc_m + opnd + cin;
      nib = acc_m[3:0] + opnd[3:0] + cin;
      res = sum[7:0];
      st_m[FLAG_C] = sum[8];
      st_m[FLAG_DC] = nib[4];
      st_m[FLAG_OV] = (acc_m[7] == opnd[7]) && (res[7] != acc_m[7]);
    end
    st_m[FLAG_Z] = (res == 8'h00);
    st_m[FLAG_N] = res[7];
    if (to_file) begin
      check("write data", mem_wdata, res);
    end else begin
      acc_m = res;
    end
    step();
    check("done", done, 1'b1);
    check("accumulator", acc_out, acc_m);
    check("status", status_out, st_m);
    if (to_file) begin
      check("file byte", mem.cells[addr], res);
    end
  endtask : exec
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    mem.cells[12'h002] = 8'h02;
    mem.cells[12'hF70] = 8'hC2;
    mem.cells[12'h320] = 8'h80;
    mem.cells[12'h25F] = 8'h7F;
    mem.cells[12'hF60] = 8'h01;
    repeat (4) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    check("reset acc", acc_out, ACC_RESET);
    check("reset status", status_out, STATUS_RESET);
    check("reset phase", phase_out, PH_DECODE);
    step();
    step();
    exec(16'h0F10, 12'h000, 1'b0);
    exec(16'h0F15, 12'h000, 1'b0);
    exec(16'h0F7E, 12'h000, 1'b0);
    exec(16'h0B5F, 12'h000, 1'b0);
    exec(16'h0FFD, 12'h000, 1'b1);
    $display("test immediate done");
    exec(16'h2002, 12'h002, 1'b0);
    exec(16'h2670, 12'hF70, 1'b0);
    bank_select_register = 4'h3;
    exec(16'h2520, 12'h320, 1'b0);
    exec(16'h2320, 12'h320, 1'b0);
    $display("test file adds done");
    ext_set_enable = 1'b1;
    exec(16'h245F, 12'h25F, 1'b0);
    exec(16'h2460, 12'hF60, 1'b0);
    $display("test indexed done");
    // An unknown opcode must leave the datapath idle in decode
    instr_valid = 1'b1;
    instr_word = 16'hFFFF;
    step();
    step();
    instr_valid = 1'b0;
    check("busy on unknown opcode", busy, 1'b0);
    check("phase on unknown opcode", phase_out, PH_DECODE);
    check("address held", mem_addr, 12'hF60);
    $display("test refused done");
    report_and_stop();
  end
endmodule : tb_top
